//--- common/rts_consts.svh
// Constants for the dual six-throw route decoder: offsets, fields, timing.
// Assumes inclusion by bare name from every file that needs them.
`ifndef RTS_CONSTS_SVH
`define RTS_CONSTS_SVH

// ----------------------------------------------------------------------
// Register addresses (five-bit serial bus address)
// ----------------------------------------------------------------------
`define RTS_ADDR_ROUTE_B   5'h00
`define RTS_ADDR_ROUTE_A   5'h01
`define RTS_ADDR_PM_TRIG   5'h1c
`define RTS_ADDR_PRODUCT   5'h1d
`define RTS_ADDR_MANUF     5'h1e
`define RTS_ADDR_MAN_BUS_SLAVE_IDENTIFIER  5'h1f

// ----------------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------------
`define RTS_ROUTE_RESET    8'h00
`define RTS_BUS_SLAVE_IDENTIFIER_RESET     4'hb
`define RTS_MASK_RESET     3'h0
`define RTS_ROUTE_MAX      8'h15
`define RTS_PM_LOWPWR      7
`define RTS_PM_STARTUP     6
`define RTS_PM_MASK_LSB    3
`define RTS_PM_TRIG_LSB    0

// ----------------------------------------------------------------------
// Frame shape
// ----------------------------------------------------------------------
`define RTS_CMD_WRITE      2'b10
`define RTS_CMD_READ       2'b11
`define RTS_CMD_LAST       4'hc
`define RTS_DATA_LAST      4'h8
`define RTS_RD_LAST        4'h9

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RTS_MCLK_MHZ       100
`define RTS_T_SW_NS        1000
`define RTS_T_ON_NS        5000
`define RTS_SW_CYC         ((`RTS_T_SW_NS * `RTS_MCLK_MHZ) / 1000)
`define RTS_ON_CYC         ((`RTS_T_ON_NS * `RTS_MCLK_MHZ) / 1000)
`define RTS_CNT_W          10

`endif

//--- common/rts_pkg.sv
// Types shared by the route decoder and its serial bus slave.
// Assumes nothing beyond a SystemVerilog compiler.
package rts_pkg;

  // Throw controls, bit 0 is throw 1
  typedef struct packed {
    logic [5:0] a_throw;
    logic [5:0] b_throw;
  } rts_route_t;

  // One register write from the serial bus
  typedef struct packed {
    logic       valid;
    logic [4:0] addr;
    logic [7:0] data;
  } rts_wr_t;

  // Settled pin level with its edges
  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } rts_line_t;

  typedef enum logic [5:0] {
    RTS_IDLE  = 6'b000001,
    RTS_CMD   = 6'b000010,
    RTS_WDATA = 6'b000100,
    RTS_RPARK = 6'b001000,
    RTS_RDATA = 6'b010000,
    RTS_REND  = 6'b100000
  } rts_bus_state_t;

endpackage : rts_pkg

//--- rtl/rts_rffe_slave.sv
// Serial front-end bus slave: frames, parity, slave match, read drive.
// Assumes settled sclk/sdata levels and edges from the owner's syncs.
`timescale 1ns/1ps
`default_nettype none
`include "rts_consts.svh"

module rts_rffe_slave
  import rts_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire rts_line_t  sclk,
  input  wire rts_line_t  sdata,
  input  wire logic [3:0] bus_slave_identifier,
  input  wire logic [7:0] rd_data,
  output logic      [4:0] rd_addr,
  output var rts_wr_t     wr,
  output logic            sdata_out,
  output logic            sdata_oe
);

  rts_bus_state_t state,  next_state;
  logic [3:0]     cnt,    next_cnt;
  logic [12:0]    sh,     next_sh;
  logic           armed,  next_armed;
  logic [4:0]     next_rd_addr;
  rts_wr_t        next_wr;
  logic           next_sdata_out;
  logic           next_sdata_oe;
  logic [12:0]    frame;
  logic           ssc;

  assign frame = {sh[11:0], sdata.level};
  // Start: data pulse while clock stays low
  assign ssc   = sdata.fall && !sclk.level && armed;

  // ----------------------------------------------------------------------
  // Frame sequencing
  // ----------------------------------------------------------------------
  always_comb begin
    next_state     = state;
    next_cnt       = cnt;
    next_sh        = sh;
    next_rd_addr   = rd_addr;
    next_wr        = '0;
    next_sdata_out = sdata_out;
    next_sdata_oe  = sdata_oe;
    next_armed     = armed;
    if (sclk.rise) begin
      next_armed = 1'b0;
    end else if (sdata.rise && !sclk.level) begin
      next_armed = 1'b1;
    end
    if (ssc) begin
      next_armed     = 1'b0;
      next_state     = RTS_CMD;
      next_cnt       = 4'h0;
      next_sdata_oe  = 1'b0;
      next_sdata_out = 1'b0;
    end else begin
      unique case (state)
        RTS_IDLE: begin
        end
        RTS_CMD: begin
          if (sclk.fall) begin
            next_sh  = frame;
            next_cnt = cnt + 4'h1;
            if (cnt == `RTS_CMD_LAST) begin
              next_state   = RTS_IDLE;
              next_rd_addr = frame[5:1];
              if (^frame && frame[12:9] == bus_slave_identifier) begin
                if (frame[8]) begin
                  next_wr = {1'b1, `RTS_ADDR_ROUTE_B, 1'b0, frame[7:1]};
                end else if (frame[7:6] == `RTS_CMD_WRITE) begin
                  next_state = RTS_WDATA;
                end else if (frame[7:6] == `RTS_CMD_READ) begin
                  next_state = RTS_RPARK;
                end
              end
              next_cnt = 4'h0;
            end
          end
        end
        RTS_WDATA: begin
          if (sclk.fall) begin
            next_sh  = frame;
            next_cnt = cnt + 4'h1;
            if (cnt == `RTS_DATA_LAST) begin
              next_state = RTS_IDLE;
              if (^frame[8:0]) begin
                next_wr = {1'b1, rd_addr, frame[8:1]};
              end
            end
          end
        end
        RTS_RPARK: begin
          if (sclk.fall) begin
            next_state = RTS_RDATA;
            next_cnt   = 4'h0;
            next_sh    = {4'h0, rd_data, ~^rd_data};
          end
        end
        RTS_RDATA: begin
          if (sclk.rise) begin
            next_sdata_oe = 1'b1;
            next_cnt      = cnt + 4'h1;
            if (cnt == `RTS_RD_LAST) begin
              // Park: drive low for half a cycle, then let go
              next_sdata_out = 1'b0;
              next_state     = RTS_REND;
            end else begin
              next_sdata_out = sh[8];
              next_sh        = {sh[11:0], 1'b0};
            end
          end
        end
        RTS_REND: begin
          if (sclk.fall) begin
            next_sdata_oe = 1'b0;
            next_state    = RTS_IDLE;
          end
        end
        default: begin
          next_state = RTS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state     <= RTS_IDLE;
      cnt       <= 4'h0;
      sh        <= 13'h0000;
      armed     <= 1'b0;
      rd_addr   <= 5'h00;
      wr        <= '0;
      sdata_out <= 1'b0;
      sdata_oe  <= 1'b0;
    end else begin
      state     <= next_state;
      cnt       <= next_cnt;
      sh        <= next_sh;
      armed     <= next_armed;
      rd_addr   <= next_rd_addr;
      wr        <= next_wr;
      sdata_out <= next_sdata_out;
      sdata_oe  <= next_sdata_oe;
    end
  end

endmodule : rts_rffe_slave
`default_nettype wire

//--- rtl/rts_route_top.sv
// Dual six-throw route decoder with its serial register port.
// Assumes sclk and sdata arrive as raw pins; sdata is a two-way pin.
//
// What this block does
// - The first route register steers only port B, the second only A.
// - An all-zero route register isolates every throw of its port.
// - Port B values 1 to 6 close exactly B throw 1 to B throw 6.
// - Port A values 1 to 6 close exactly A throw 1 to A throw 6.
// - Port B values 7 to 21 close the pairs 6+5 down to 2+1 in order.
// - Port A values 7 to 21 close the same ordered pairs as port B.
// - Code 0x15 is the last defined one and closes throws 2 and 1.
// - A new path is in place within 2 us of the register taking effect.
// - After power-up the throws become active within 10 us.
// - Route B sits at 0x00, route A at 0x01, both read/write, reset 0.
// - Unmasked triggers route writes to a shadow, loaded on trigger.
// - Writes, reads and zero-writes arrive as framed serial commands.
`timescale 1ns/1ps
`default_nettype none
`include "rts_consts.svh"

module rts_route_top
  import rts_pkg::*;
#(
  parameter logic [7:0] PRODUCT_ID = 8'h00,   // Arbitrary value
  parameter logic [9:0] MANUF_ID   = 10'h155  // Arbitrary value
)(
  input  wire logic      mclk,
  input  wire logic      srst,
  input  wire logic      sclk,
  input  wire logic      sdata_in,
  output logic           sdata_out,
  output logic           sdata_oe,
  output var rts_route_t throw_ctl,
  output logic           rf_ready
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Route code to throw mask, bit 0 is throw 1
  function automatic logic [5:0] rts_decode(input logic [7:0] code);
    logic [5:0] m;
    m = 6'h00;
    unique case (code)
      8'h01: m = 6'h01;
      8'h02: m = 6'h02;
      8'h03: m = 6'h04;
      8'h04: m = 6'h08;
      8'h05: m = 6'h10;
      8'h06: m = 6'h20;
      8'h07: m = 6'h30;
      8'h08: m = 6'h28;
      8'h09: m = 6'h24;
      8'h0a: m = 6'h22;
      8'h0b: m = 6'h21;
      8'h0c: m = 6'h18;
      8'h0d: m = 6'h14;
      8'h0e: m = 6'h12;
      8'h0f: m = 6'h11;
      8'h10: m = 6'h0c;
      8'h11: m = 6'h0a;
      8'h12: m = 6'h09;
      8'h13: m = 6'h06;
      8'h14: m = 6'h05;
      8'h15: m = 6'h03;
      default: m = 6'h00;
    endcase
    return m;
  endfunction : rts_decode

  // Settled level update: second and third stage must agree
  function automatic rts_line_t rts_settle(input logic [2:0] s,
                                           input logic       lvl);
    rts_line_t r;
    r.level = (s[1] == s[2]) ? s[2] : lvl;
    r.rise  = r.level && !lvl;
    r.fall  = !r.level && lvl;
    return r;
  endfunction : rts_settle

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] sclk_s,  next_sclk_s;
  logic [2:0] sdata_s, next_sdata_s;
  rts_line_t  sclk_l,  next_sclk_l;
  rts_line_t  sdata_l, next_sdata_l;

  always_comb begin
    next_sclk_s  = {sclk_s[1:0], sclk};
    next_sdata_s = {sdata_s[1:0], sdata_in};
    next_sclk_l  = rts_settle(sclk_s, sclk_l.level);
    next_sdata_l = rts_settle(sdata_s, sdata_l.level);
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      sclk_s  <= 3'h0;
      sdata_s <= 3'h0;
      sclk_l  <= '0;
      sdata_l <= '0;
    end else begin
      sclk_s  <= next_sclk_s;
      sdata_s <= next_sdata_s;
      sclk_l  <= next_sclk_l;
      sdata_l <= next_sdata_l;
    end
  end

  // ----------------------------------------------------------------------
  // Serial slave
  // ----------------------------------------------------------------------
  rts_wr_t    wr;
  logic [4:0] rd_addr;
  logic [7:0] rd_data;
  logic [3:0] bus_slave_identifier;

  rts_rffe_slave u_slave (
    .mclk      (mclk),
    .srst      (srst),
    .sclk      (sclk_l),
    .sdata     (sdata_l),
    .bus_slave_identifier      (bus_slave_identifier),
    .rd_data   (rd_data),
    .rd_addr   (rd_addr),
    .wr        (wr),
    .sdata_out (sdata_out),
    .sdata_oe  (sdata_oe)
  );

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  logic [7:0] route_b,  next_route_b;
  logic [7:0] route_a,  next_route_a;
  logic [7:0] shadow_b, next_shadow_b;
  logic [7:0] shadow_a, next_shadow_a;
  logic [2:0] masks,    next_masks;
  logic       lowpwr,   next_lowpwr;
  logic [3:0] next_bus_slave_identifier;
  logic       direct;
  logic       fire;

  // Writes bypass the shadow only when every trigger is masked
  assign direct = &masks;
  assign fire   = wr.valid && wr.addr == `RTS_ADDR_PM_TRIG
                  && |(wr.data[`RTS_PM_TRIG_LSB +: 3]
                       & ~wr.data[`RTS_PM_MASK_LSB +: 3]);

  always_comb begin
    next_route_b  = route_b;
    next_route_a  = route_a;
    next_shadow_b = shadow_b;
    next_shadow_a = shadow_a;
    next_masks    = masks;
    next_lowpwr   = lowpwr;
    next_bus_slave_identifier     = bus_slave_identifier;
    if (wr.valid) begin
      unique case (wr.addr)
        `RTS_ADDR_ROUTE_B: begin
          next_shadow_b = wr.data;
          if (direct) begin
            next_route_b = wr.data;
          end
        end
        `RTS_ADDR_ROUTE_A: begin
          next_shadow_a = wr.data;
          if (direct) begin
            next_route_a = wr.data;
          end
        end
        `RTS_ADDR_PM_TRIG: begin
          next_masks  = wr.data[`RTS_PM_MASK_LSB +: 3];
          next_lowpwr = wr.data[`RTS_PM_LOWPWR];
          if (fire) begin
            next_route_b = shadow_b;
            next_route_a = shadow_a;
          end
          if (wr.data[`RTS_PM_STARTUP]) begin
            next_route_b  = `RTS_ROUTE_RESET;
            next_route_a  = `RTS_ROUTE_RESET;
            next_shadow_b = `RTS_ROUTE_RESET;
            next_shadow_a = `RTS_ROUTE_RESET;
            next_masks    = `RTS_MASK_RESET;
            next_lowpwr   = 1'b0;
          end
        end
        `RTS_ADDR_MAN_BUS_SLAVE_IDENTIFIER: begin
          next_bus_slave_identifier = wr.data[3:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      route_b  <= `RTS_ROUTE_RESET;
      route_a  <= `RTS_ROUTE_RESET;
      shadow_b <= `RTS_ROUTE_RESET;
      shadow_a <= `RTS_ROUTE_RESET;
      masks    <= `RTS_MASK_RESET;
      lowpwr   <= 1'b0;
      bus_slave_identifier     <= `RTS_BUS_SLAVE_IDENTIFIER_RESET;
    end else begin
      route_b  <= next_route_b;
      route_a  <= next_route_a;
      shadow_b <= next_shadow_b;
      shadow_a <= next_shadow_a;
      masks    <= next_masks;
      lowpwr   <= next_lowpwr;
      bus_slave_identifier     <= next_bus_slave_identifier;
    end
  end

  // Read mux; trigger bits read as zero
  always_comb begin
    unique case (rd_addr)
      `RTS_ADDR_ROUTE_B:  rd_data = route_b;
      `RTS_ADDR_ROUTE_A:  rd_data = route_a;
      `RTS_ADDR_PM_TRIG:  rd_data = {lowpwr, 1'b0, masks, 3'h0};
      `RTS_ADDR_PRODUCT:  rd_data = PRODUCT_ID;
      `RTS_ADDR_MANUF:    rd_data = MANUF_ID[7:0];
      `RTS_ADDR_MAN_BUS_SLAVE_IDENTIFIER: rd_data = {2'h0, MANUF_ID[9:8], bus_slave_identifier};
      default:            rd_data = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------------
  // Power-up and switching timers
  // ----------------------------------------------------------------------
  localparam logic [`RTS_CNT_W-1:0] ON_LAST =
    `RTS_CNT_W'(`RTS_ON_CYC - 1);
  localparam logic [`RTS_CNT_W-1:0] SW_LAST =
    `RTS_CNT_W'(`RTS_SW_CYC - 1);

  logic [`RTS_CNT_W-1:0] on_cnt, next_on_cnt;
  logic [`RTS_CNT_W-1:0] sw_cnt, next_sw_cnt;
  logic                  next_rf_ready;
  rts_route_t            target;
  rts_route_t            next_throw_ctl;

  always_comb begin
    target.b_throw = rts_decode(route_b);
    target.a_throw = rts_decode(route_a);
    if (!rf_ready || lowpwr) begin
      target = '0;
    end
    next_on_cnt    = on_cnt;
    next_rf_ready  = rf_ready;
    next_sw_cnt    = '0;
    next_throw_ctl = throw_ctl;
    if (!rf_ready) begin
      next_on_cnt = on_cnt + `RTS_CNT_W'(1);
      if (on_cnt == ON_LAST) begin
        next_rf_ready = 1'b1;
      end
    end
    if (target != throw_ctl) begin
      next_sw_cnt = sw_cnt + `RTS_CNT_W'(1);
      if (sw_cnt == SW_LAST) begin
        next_throw_ctl = target;
        next_sw_cnt    = '0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      on_cnt    <= '0;
      sw_cnt    <= '0;
      rf_ready  <= 1'b0;
      throw_ctl <= '0;
    end else begin
      on_cnt    <= next_on_cnt;
      sw_cnt    <= next_sw_cnt;
      rf_ready  <= next_rf_ready;
      throw_ctl <= next_throw_ctl;
    end
  end

endmodule : rts_route_top
`default_nettype wire

//--- dv/rts_route_top_props.sv
// Checker on the route decoder pins: reset, power-up, switching, reads.
// Assumes binding onto rts_route_top; mclk is the only clock.
`timescale 1ns/1ps
`default_nettype none
module rts_route_top_props
  import rts_pkg::*;
(
  input wire logic       mclk,
  input wire logic       srst,
  input wire logic       sclk,
  input wire logic       sdata_in,
  input wire logic       sdata_out,
  input wire logic       sdata_oe,
  input wire rts_route_t throw_ctl,
  input wire logic       rf_ready
);
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  logic [9:0] up_cnt, next_up_cnt, gap_cnt, next_gap_cnt;
  rts_route_t prev_ctl;
  always_comb begin
    next_up_cnt = (up_cnt == 10'h3ff) ? up_cnt : up_cnt + 10'h001;
    next_gap_cnt = (throw_ctl != prev_ctl) ? 10'h000 :
                   (gap_cnt == 10'h3ff) ? gap_cnt : gap_cnt + 10'h001;
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      up_cnt   <= 10'h000;
      gap_cnt  <= 10'h000;
      prev_ctl <= '0;
    end else begin
      up_cnt   <= next_up_cnt;
      gap_cnt  <= next_gap_cnt;
      prev_ctl <= throw_ctl;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  sequence s_release;
    srst ##1 !srst;
  endsequence
  a_reset_quiet: assert property (disable iff (1'b0) s_release |->
    throw_ctl == '0 && !sdata_oe && !rf_ready)
    else $error("outputs not quiet after reset");
  a_ready_time: assert property ($rose(rf_ready) |->
    up_cnt inside {[10'd498:10'd502]}) else $error("ready at wrong time");
  a_ready_limit: assert property (up_cnt == 10'd1000 |-> rf_ready)
    else $error("not ready within limit");
  a_dark_early: assert property (!rf_ready |-> throw_ctl == '0)
    else $error("throws closed before ready");
  a_two_most: assert property ($countones(throw_ctl.a_throw) <= 2 &&
    $countones(throw_ctl.b_throw) <= 2) else $error("too many throws");
  a_switch_gap: assert property ($changed(throw_ctl) |->
    gap_cnt >= 10'd99) else $error("throws changed too soon");
  a_oe_rise: assert property ($rose(sdata_oe) |-> sclk)
    else $error("read drive began off clock high");
  a_oe_fall: assert property ($fell(sdata_oe) |-> !sclk)
    else $error("read drive ended off clock low");
  a_out_high: assert property ($changed(sdata_out) |-> sclk)
    else $error("read data moved off clock high");
endmodule : rts_route_top_props
bind rts_route_top rts_route_top_props u_props (.mclk(mclk), .srst(srst),
  .sclk(sclk), .sdata_in(sdata_in), .sdata_out(sdata_out),
  .sdata_oe(sdata_oe), .throw_ctl(throw_ctl), .rf_ready(rf_ready));
`default_nettype wire

//--- dv/rts_rffe_master.sv
// Serial bus master model: start, command, data, park and read frames.
// Assumes the bench resolves the shared data line from both enables.
`timescale 1ns/1ps
`default_nettype none
module rts_rffe_master (
  input  wire logic mclk,
  output logic      sclk,
  output logic      sd_drv,
  output logic      sd_oe,
  input  wire logic sd_wire
);
  initial begin
    sclk   = 1'b0;
    sd_drv = 1'b0;
    sd_oe  = 1'b0;
  end
  // Clock stands low outside frames; phase kept off mclk edges
  task automatic bit_out(input logic b);
    sclk   = 1'b1;
    sd_oe  = 1'b1;
    sd_drv = b;
    #62.5;
    sclk = 1'b0;
    #62.5;
  endtask : bit_out
  task automatic ssc();
    @(negedge mclk);
    #2;
    sd_oe  = 1'b1;
    sd_drv = 1'b0;
    #62.5;
    sd_drv = 1'b1;
    #62.5;
    sd_drv = 1'b0;
    #62.5;
  endtask : ssc
  task automatic park();
    sclk   = 1'b1;
    sd_drv = 1'b0;
    #62.5;
    sclk  = 1'b0;
    sd_oe = 1'b0;
    #62.5;
  endtask : park
  task automatic cmd(input logic [3:0] sa, input logic [7:0] c,
                     input logic bad);
    logic [12:0] w;
    w = {sa, c, ~^{sa, c} ^ bad};
    for (int i = 12; i >= 0; i--) bit_out(w[i]);
  endtask : cmd
  task automatic write_reg(input logic [3:0] sa, input logic [4:0] addr,
                           input logic [7:0] data, input logic bad);
    logic [8:0] w;
    w = {data, ~^data};
    ssc();
    cmd(sa, {3'b010, addr}, bad);
    for (int i = 8; i >= 0; i--) bit_out(w[i]);
    park();
  endtask : write_reg
  task automatic zero_write(input logic [3:0] sa, input logic [6:0] d);
    ssc();
    cmd(sa, {1'b1, d}, 1'b0);
    park();
  endtask : zero_write
  task automatic read_reg(input logic [3:0] sa, input logic [4:0] addr,
                          output logic [7:0] d, output logic ok);
    logic [8:0] w;
    ssc();
    cmd(sa, {3'b011, addr}, 1'b0);
    park();
    for (int i = 8; i >= 0; i--) begin
      sclk = 1'b1;
      #62.5;
      w[i] = sd_wire;
      sclk = 1'b0;
      #62.5;
    end
    sclk = 1'b1;
    #62.5;
    sclk = 1'b0;
    #62.5;
    d  = w[8:1];
    ok = (w[0] === ~^w[8:1]);
  endtask : read_reg
endmodule : rts_rffe_master
`default_nettype wire

//--- dv/test_rts_route_top.sv
// Bench for the route decoder: decode sweep, shadow, refusals, reset.
// Assumes the master model and the bound checker beside the design.
`timescale 1ns/1ps
`default_nettype none
`include "rts_consts.svh"
module test_rts_route_top
  import rts_pkg::*;
;
  localparam logic [3:0] SA = `RTS_BUS_SLAVE_IDENTIFIER_RESET;
  logic       mclk, srst, sclk, m_drv, m_oe, sdata_out, sdata_oe, rf_ready;
  logic       ok;
  logic [7:0] rd, va, vb;
  wire logic  sd_wire;
  rts_route_t throw_ctl;
  int         errors, checked, seed, n;
  // Undriven line shows the inverse of the last driven level
  assign sd_wire = sdata_oe ? sdata_out : (m_oe ? m_drv : ~m_drv);
  rts_route_top dut (.mclk(mclk), .srst(srst), .sclk(sclk),
    .sdata_in(sd_wire), .sdata_out(sdata_out), .sdata_oe(sdata_oe),
    .throw_ctl(throw_ctl), .rf_ready(rf_ready));
  rts_rffe_master bfm (.mclk(mclk), .sclk(sclk), .sd_drv(m_drv),
    .sd_oe(m_oe), .sd_wire(sd_wire));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ----------------------------------------------------------------
  // Expectations and checks
  // ----------------------------------------------------------------
  function automatic logic [5:0] dec(input logic [7:0] v);
    int k;
    logic [5:0] r;
    k = 7;
    r = 6'h00;
    if (v >= 1 && v <= 6) r = 6'h01 << (v - 1);
    for (int h = 6; h >= 2; h--) begin
      for (int l = h - 1; l >= 1; l--) begin
        if (v == k) r = (6'h01 << (h - 1)) | (6'h01 << (l - 1));
        k++;
      end
    end
    return r;
  endfunction : dec
  function automatic rts_route_t exp_ctl(input logic [7:0] a,
                                         input logic [7:0] b);
    return rts_route_t'({dec(a), dec(b)});
  endfunction : exp_ctl
  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask : check
  task automatic final_report();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report
  task automatic wait_throw(input rts_route_t exp, output int cnt);
    cnt = 0;
    while (throw_ctl !== exp && cnt < 400) begin
      @(negedge mclk);
      cnt++;
    end
    if (cnt >= 400) begin
      errors++;
      $display("unexpected at %0t: throw wait ran out", $time);
      final_report();
    end
  endtask : wait_throw
  task automatic reset_up();
    srst = 1'b1;
    repeat (3) @(negedge mclk);
    srst = 1'b0;
    check(throw_ctl, 16'h0, "reset throws");
    check(rf_ready, 16'h0, "ready early");
    n = 0;
    while (rf_ready !== 1'b1 && n < 1200) begin
      @(negedge mclk);
      n++;
    end
    check(16'(n <= 1000), 16'h1, "power-up time");
    if (rf_ready !== 1'b1) final_report();
    bfm.read_reg(SA, `RTS_ADDR_ROUTE_B, rd, ok);
    check({ok, rd}, 16'h100, "route b reset");
    bfm.read_reg(SA, `RTS_ADDR_ROUTE_A, rd, ok);
    check({ok, rd}, 16'h100, "route a reset");
  endtask : reset_up
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    errors = 0;
    checked = 0;
    seed = 32'habc8;
    reset_up();
    $display("test reset done");
    bfm.write_reg(SA, `RTS_ADDR_ROUTE_B, 8'h03, 1'b0);
    repeat (200) @(negedge mclk);
    check(throw_ctl, 16'h0, "shadow leaked");
    bfm.read_reg(SA, `RTS_ADDR_ROUTE_B, rd, ok);
    check(rd, 16'h0, "active before trigger");
    bfm.write_reg(SA, `RTS_ADDR_PM_TRIG, 8'h01, 1'b0);
    wait_throw(exp_ctl(8'h00, 8'h03), n);
    check(16'(n <= 200), 16'h1, "trigger load time");
    $display("test trigger done");
    bfm.write_reg(SA, `RTS_ADDR_PM_TRIG, 8'h38, 1'b0);
    for (int v = 0; v < 28; v++) begin
      vb = (v < 24) ? 8'(v) : 8'($random(seed));
      va = (v < 24) ? 8'(23 - v) : 8'($random(seed));
      bfm.write_reg(SA, `RTS_ADDR_ROUTE_B, vb, 1'b0);
      bfm.write_reg(SA, `RTS_ADDR_ROUTE_A, va, 1'b0);
      wait_throw(exp_ctl(va, vb), n);
      check(throw_ctl, exp_ctl(va, vb), "decode");
      check(throw_ctl.b_throw, dec(vb), "b");
      check(throw_ctl.a_throw, dec(va), "a");
      check(16'(n <= 200), 16'h1, "switch time");
    end
    bfm.read_reg(SA, `RTS_ADDR_ROUTE_A, rd, ok);
    check({ok, rd}, {8'h01, va}, "route a readback");
    $display("test decode done");
    bfm.zero_write(SA, 7'h12);
    wait_throw(exp_ctl(va, 8'h12), n);
    bfm.read_reg(SA, `RTS_ADDR_ROUTE_B, rd, ok);
    check(rd, 16'h12, "zero write");
    bfm.write_reg(SA, `RTS_ADDR_ROUTE_B, 8'h05, 1'b1);
    bfm.write_reg(4'h3, `RTS_ADDR_ROUTE_B, 8'h06, 1'b0);
    repeat (200) @(negedge mclk);
    check(throw_ctl, exp_ctl(va, 8'h12), "refused frame");
    bfm.read_reg(SA, 5'h05, rd, ok);
    check({ok, rd}, 16'h100, "unmapped read");
    $display("test frames done");
    bfm.write_reg(SA, `RTS_ADDR_PM_TRIG, 8'h40, 1'b0);
    wait_throw(exp_ctl(8'h00, 8'h00), n);
    bfm.read_reg(SA, `RTS_ADDR_PM_TRIG, rd, ok);
    check({ok, rd}, 16'h100, "startup clear");
    bfm.write_reg(SA, `RTS_ADDR_PM_TRIG, 8'hb8, 1'b0);
    bfm.write_reg(SA, `RTS_ADDR_ROUTE_B, 8'h12, 1'b0);
    repeat (200) @(negedge mclk);
    check(throw_ctl, 16'h0, "low power");
    bfm.read_reg(SA, `RTS_ADDR_ROUTE_B, rd, ok);
    check({ok, rd}, 16'h112, "low power route");
    bfm.write_reg(SA, `RTS_ADDR_PM_TRIG, 8'h38, 1'b0);
    wait_throw(exp_ctl(8'h00, 8'h12), n);
    check(16'(n <= 200), 16'h1, "wake time");
    $display("test power done");
    @(negedge mclk);
    reset_up();
    $display("test second reset done");
    final_report();
  end
endmodule : test_rts_route_top
`default_nettype wire
